// File: core/i2m_master.sv
/*
 * i2c master controller with start, repeated start, stop, byte transfer and
 * acknowledge sequencing, start/stop detection and apb registers.
 * assumes open-drain sda/scl pins outside (oe high pulls the line low) and
 * a zero-wait apb master on pclk.
 */
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "i2m_map.svh"

//
// Overview of operation
// - master only with master mode and enable
// - pull lines low only when needed
// - reset or disable clears start/stop seen
// - firmware mode: detection only, software drives lines
// - event flag on conditions, bytes, acks
// - no queuing: early buffer write collides
// - master: flag on request self-clear or end of byte
// - master makes clocks; restart keeps bus
// - transmit: address, direction zero, bytes, ack
// - receive: address, direction one, return ack
// - clock rate from 8-bit baud reload
// - released clock: count after sampled high
// - buffer write while busy sets collision
// - low request bits locked during start
// - start: both high, count, pull data
// - then count, clear request, hold data
// - low clock during start wait aborts with collision
// - restart only idle; clock low, count
// - data high then release clock, count
// - data low, clock low, clear request
// - restart: start seen early, flag later
module i2m_master
   import i2m_pkg::*;
(
   // clock, reset, enable
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // i2c lines
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe,
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe
);

   // ******************************
   // registers and state
   // ******************************
   i2m_state_t  state_q;
   i2m_op_t     op_q;
   logic [3:0]  mode_q;
   logic        en_q;
   logic        sen_q, restart_request_bit_q, pen_q, rcen_q, acken_q;
   logic        ackdt_q, ackstat_q;
   logic        sseen_q, pseen_q, bf_q;
   logic        evt_q, write_collision_flag_q, bcol_q;
   logic        fw_sda_q, fw_scl_q;
   logic [7:0]  baud_q, buf_q, sh_q;
   logic [3:0]  bit_q;
   logic        sda_drv_q, scl_drv_q, load_q;
   logic        sda_m_q, sda_s_q, sda_p_q;
   logic        scl_m_q, scl_s_q, scl_p_q;
   logic [31:0] prdata_q;

   i2m_baud_if bd ();

   i2m_baud_counter u_baud (
      .presetn (presetn),
      .pclk    (pclk),
      .bd      (bd)
   );

   // ******************************
   // decode
   // ******************************
   wire acc      = psel & penable;
   wire wr       = acc & pwrite;
   wire rd       = acc & ~pwrite;
   wire hit_c1   = (paddr == `I2M_OFS_CTRL1);
   wire hit_c2   = (paddr == `I2M_OFS_CTRL2);
   wire hit_st   = (paddr == `I2M_OFS_STATUS);
   wire hit_buf  = (paddr == `I2M_OFS_BUF);
   wire hit_baud = (paddr == `I2M_OFS_BAUD);
   wire hit_fl   = (paddr == `I2M_OFS_FLAGS);
   wire hit_pn   = (paddr == `I2M_OFS_PINS);
   wire mapped   = hit_c1 | hit_c2 | hit_st | hit_buf | hit_baud | hit_fl | hit_pn;

   wire master   = en_q & (mode_q == `I2M_MODE_MASTER);
   wire fwmode   = en_q & (mode_q == `I2M_MODE_FW);
   wire idle     = (state_q == I2M_IDLE);
   wire req_any  = sen_q | restart_request_bit_q | pen_q | rcen_q | acken_q;
   wire busy     = ~idle | req_any;
   // no queuing: buffer only accepted with sequencer idle and nothing pending
   wire buf_wr   = wr & hit_buf;
   wire buf_ok   = buf_wr & master & ~busy;
   wire buf_col  = buf_wr & master & busy;
   wire c2_wr    = wr & hit_c2;
   wire c2_req   = c2_wr & master & ~busy;

   // ******************************
   // line sampling and detection
   // ******************************
   wire both_hi  = sda_s_q & scl_s_q;
   wire det_st   = sda_p_q & ~sda_s_q & scl_s_q & scl_p_q;
   wire det_sp   = ~sda_p_q & sda_s_q & scl_s_q & scl_p_q;
   wire hi_phase = (state_q == I2M_RS_SCL) | (state_q == I2M_BIT_HI) | (state_q == I2M_SP_HI);
   wire timed    = (state_q == I2M_ST_HOLD) | (state_q == I2M_RS_SDA) | (state_q == I2M_RS_DRV) |
                   (state_q == I2M_BIT_LO) | (state_q == I2M_SP_LO) | (state_q == I2M_SP_SDA);
   wire tmo      = bd.timeout;

   // counter waits for the released clock to read high before counting
   assign bd.ce     = ce;
   assign bd.reload = baud_q;
   assign bd.load   = load_q | (hi_phase & ~scl_s_q) |
                      ((state_q == I2M_ST_WAIT) & ~both_hi);
   assign bd.run    = timed | (hi_phase & scl_s_q) |
                      ((state_q == I2M_ST_WAIT) & both_hi);

   // ******************************
   // bit engine helpers
   // ******************************
   wire [3:0] nbits   = (op_q == I2M_OP_TX) ? `I2M_TX_BITS :
                        (op_q == I2M_OP_RX) ? `I2M_RX_BITS : `I2M_ACK_BITS;
   wire       last    = (bit_q == nbits - 4'h1);
   wire [3:0] bit_nx  = bit_q + 4'h1;
   // drive low: tx data zero, ack sequence with ackdt zero; else release
   wire       bit_low = (op_q == I2M_OP_TX) ? ((bit_nx < 4'h8) & ~sh_q[6]) :
                        (op_q == I2M_OP_ACK) ? ~ackdt_q : 1'h0;
   wire       tx_low0 = ~pwdata[7];

   // ******************************
   // pin outputs
   // ******************************
   assign sda_o  = 1'h0;
   assign scl_o  = 1'h0;
   assign sda_oe = master ? sda_drv_q : (fwmode & fw_sda_q);
   assign scl_oe = master ? scl_drv_q : (fwmode & fw_scl_q);

   // ******************************
   // apb
   // ******************************
   assign pready  = 1'h1;
   assign pslverr = acc & ~mapped;
   assign prdata  = prdata_q;

   wire [31:0] rd_mux =
      hit_c1   ? {26'h0, en_q, 1'h0, mode_q} :
      hit_c2   ? {25'h0, ackstat_q, ackdt_q, acken_q, rcen_q, pen_q, restart_request_bit_q, sen_q} :
      hit_st   ? {28'h0, busy, bf_q, pseen_q, sseen_q} :
      hit_buf  ? {24'h0, buf_q} :
      hit_baud ? {24'h0, baud_q} :
      hit_fl   ? {29'h0, bcol_q, write_collision_flag_q, evt_q} :
      hit_pn   ? {30'h0, fw_scl_q, fw_sda_q} : 32'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0;
      end else if (ce && psel && !penable && !pwrite) begin
         prdata_q <= rd_mux;
      end
   end

   // ******************************
   // synchronisers
   // ******************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sda_m_q <= 1'h1;
         sda_s_q <= 1'h1;
         sda_p_q <= 1'h1;
         scl_m_q <= 1'h1;
         scl_s_q <= 1'h1;
         scl_p_q <= 1'h1;
      end else if (ce) begin
         sda_m_q <= sda_i;
         sda_s_q <= sda_m_q;
         sda_p_q <= sda_s_q;
         scl_m_q <= scl_i;
         scl_s_q <= scl_m_q;
         scl_p_q <= scl_s_q;
      end
   end

   // ******************************
   // configuration and flags
   // ******************************
   // flags are write-one-to-clear; a hardware set in the same cycle wins
   wire ev_done = master & tmo & ((state_q == I2M_ST_HOLD) | (state_q == I2M_RS_DRV) |
                  (state_q == I2M_SP_SDA) | ((state_q == I2M_BIT_HI) & last));
   wire ev_det  = fwmode & (det_st | det_sp);
   wire bc_st   = master & (state_q == I2M_ST_WAIT) & ~scl_s_q;
   wire bc_rs   = master & (((state_q == I2M_RS_SCL) & scl_s_q & ~sda_s_q) |
                  ((state_q == I2M_RS_SDA) & tmo & ~sda_s_q));
   wire fl_clr  = wr & hit_fl;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_q     <= 1'h0;
         mode_q   <= 4'h0;
         baud_q   <= `I2M_RST_BAUD;
         fw_sda_q <= 1'h0;
         fw_scl_q <= 1'h0;
         evt_q    <= 1'h0;
         write_collision_flag_q   <= 1'h0;
         bcol_q   <= 1'h0;
         sseen_q  <= 1'h0;
         pseen_q  <= 1'h0;
      end else if (ce) begin
         if (wr && hit_c1) begin
            en_q   <= pwdata[`I2M_C1_ENABLE];
            mode_q <= pwdata[3:0];
         end
         if (wr && hit_baud) begin
            baud_q <= pwdata[7:0];
         end
         if (wr && hit_pn) begin
            fw_sda_q <= pwdata[`I2M_PN_SDA_LOW];
            fw_scl_q <= pwdata[`I2M_PN_SCL_LOW];
         end
         evt_q  <= (ev_done | ev_det) | (evt_q & ~(fl_clr & pwdata[`I2M_FL_EVENT]));
         // never cleared by hardware
         write_collision_flag_q <= buf_col | (write_collision_flag_q & ~(fl_clr & pwdata[`I2M_FL_WRITE_COLLISION_FLAG]));
         bcol_q <= (bc_st | bc_rs) | (bcol_q & ~(fl_clr & pwdata[`I2M_FL_BCOL]));
         if (!en_q) begin
            sseen_q <= 1'h0;
            pseen_q <= 1'h0;
         end else if (det_st) begin
            sseen_q <= 1'h1;
            pseen_q <= 1'h0;
         end else if (det_sp) begin
            sseen_q <= 1'h0;
            pseen_q <= 1'h1;
         end
      end
   end

   // ******************************
   // master sequencer
   // ******************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q   <= I2M_IDLE;
         op_q      <= I2M_OP_TX;
         {sen_q, restart_request_bit_q, pen_q, rcen_q, acken_q} <= 5'h00;
         ackdt_q   <= 1'h0;
         ackstat_q <= 1'h0;
         bf_q      <= 1'h0;
         buf_q     <= 8'h00;
         sh_q      <= 8'h00;
         bit_q     <= 4'h0;
         sda_drv_q <= 1'h0;
         scl_drv_q <= 1'h0;
         load_q    <= 1'h0;
      end else if (ce) begin
         load_q <= 1'h0;
         if (c2_wr) begin
            ackdt_q <= pwdata[`I2M_C2_ACKDT];
         end
         if (rd && hit_buf) begin
            bf_q <= 1'h0;
         end
         if (!master || bc_st || bc_rs) begin
            // abort: release both lines and drop every request
            state_q   <= I2M_IDLE;
            {sen_q, restart_request_bit_q, pen_q, rcen_q, acken_q} <= 5'h00;
            sda_drv_q <= 1'h0;
            scl_drv_q <= 1'h0;
         end else begin
            if (c2_req) begin
               sen_q   <= pwdata[`I2M_C2_START];
               restart_request_bit_q  <= pwdata[`I2M_C2_RESTART];
               pen_q   <= pwdata[`I2M_C2_STOP];
               rcen_q  <= pwdata[`I2M_C2_RECV];
               acken_q <= pwdata[`I2M_C2_ACKSEQ];
            end
            case (state_q)
               I2M_IDLE: begin
                  bit_q <= 4'h0;
                  if (buf_ok) begin
                     buf_q     <= pwdata[7:0];
                     sh_q      <= pwdata[7:0];
                     bf_q      <= 1'h1;
                     op_q      <= I2M_OP_TX;
                     scl_drv_q <= 1'h1;
                     sda_drv_q <= tx_low0;
                     load_q    <= 1'h1;
                     state_q   <= I2M_BIT_LO;
                  end else if (sen_q) begin
                     load_q  <= 1'h1;
                     state_q <= I2M_ST_WAIT;
                  end else if (restart_request_bit_q) begin
                     scl_drv_q <= 1'h1;
                     state_q   <= I2M_RS_LOW;
                  end else if (pen_q) begin
                     scl_drv_q <= 1'h1;
                     sda_drv_q <= 1'h1;
                     load_q    <= 1'h1;
                     state_q   <= I2M_SP_LO;
                  end else if (rcen_q || acken_q) begin
                     op_q      <= rcen_q ? I2M_OP_RX : I2M_OP_ACK;
                     scl_drv_q <= 1'h1;
                     sda_drv_q <= rcen_q ? 1'h0 : ~ackdt_q;
                     load_q    <= 1'h1;
                     state_q   <= I2M_BIT_LO;
                  end
               end
               I2M_ST_WAIT: begin
                  if (tmo) begin
                     sda_drv_q <= 1'h1;
                     load_q    <= 1'h1;
                     state_q   <= I2M_ST_HOLD;
                  end
               end
               I2M_ST_HOLD: begin
                  if (tmo) begin
                     sen_q   <= 1'h0;
                     state_q <= I2M_IDLE;
                  end
               end
               I2M_RS_LOW: begin
                  if (!scl_s_q) begin
                     sda_drv_q <= 1'h0;
                     load_q    <= 1'h1;
                     state_q   <= I2M_RS_SDA;
                  end
               end
               I2M_RS_SDA: begin
                  if (tmo) begin
                     scl_drv_q <= 1'h0;
                     state_q   <= I2M_RS_SCL;
                  end
               end
               I2M_RS_SCL: begin
                  if (tmo) begin
                     sda_drv_q <= 1'h1;
                     load_q    <= 1'h1;
                     state_q   <= I2M_RS_DRV;
                  end
               end
               I2M_RS_DRV: begin
                  // bus stays owned: clock held low, no reload
                  if (tmo) begin
                     scl_drv_q <= 1'h1;
                     restart_request_bit_q    <= 1'h0;
                     state_q   <= I2M_IDLE;
                  end
               end
               I2M_BIT_LO: begin
                  if (tmo) begin
                     scl_drv_q <= 1'h0;
                     state_q   <= I2M_BIT_HI;
                  end
               end
               I2M_BIT_HI: begin
                  if (tmo) begin
                     scl_drv_q <= 1'h1;
                     bit_q     <= bit_nx;
                     if (op_q != I2M_OP_ACK && bit_q < 4'h8) begin
                        sh_q <= {sh_q[6:0], sda_s_q};
                     end
                     if (op_q == I2M_OP_TX && bit_q == 4'h7) begin
                        bf_q <= 1'h0;
                     end
                     if (last) begin
                        if (op_q == I2M_OP_TX) begin
                           ackstat_q <= sda_s_q;
                        end
                        if (op_q == I2M_OP_RX) begin
                           buf_q <= {sh_q[6:0], sda_s_q};
                           bf_q  <= 1'h1;
                        end
                        rcen_q    <= 1'h0;
                        acken_q   <= 1'h0;
                        sda_drv_q <= (op_q == I2M_OP_TX) ? 1'h0 : sda_drv_q;
                        state_q   <= I2M_IDLE;
                     end else begin
                        sda_drv_q <= bit_low;
                        load_q    <= 1'h1;
                        state_q   <= I2M_BIT_LO;
                     end
                  end
               end
               I2M_SP_LO: begin
                  if (tmo) begin
                     scl_drv_q <= 1'h0;
                     state_q   <= I2M_SP_HI;
                  end
               end
               I2M_SP_HI: begin
                  if (tmo) begin
                     sda_drv_q <= 1'h0;
                     load_q    <= 1'h1;
                     state_q   <= I2M_SP_SDA;
                  end
               end
               I2M_SP_SDA: begin
                  if (tmo) begin
                     pen_q   <= 1'h0;
                     state_q <= I2M_IDLE;
                  end
               end
               default: begin
                  state_q <= I2M_IDLE;
               end
            endcase
         end
      end
   end

endmodule

`default_nettype wire

// File: shared/i2m_map.svh
/*
 * register offsets, field positions, reset values and mode codes of the
 * i2c master start/restart controller.
 * assumes an apb slave with 32-bit data and byte addresses on paddr[7:0].
 */
`ifndef I2M_MAP_SVH
`define I2M_MAP_SVH

// ******************************
// register byte offsets
// ******************************
`define I2M_OFS_CTRL1     8'h00
`define I2M_OFS_CTRL2     8'h04
`define I2M_OFS_STATUS    8'h08
`define I2M_OFS_BUF       8'h0c
`define I2M_OFS_BAUD      8'h10
`define I2M_OFS_FLAGS     8'h14
`define I2M_OFS_PINS      8'h18

// ******************************
// field positions
// ******************************
`define I2M_C1_ENABLE     5
`define I2M_C2_START      0
`define I2M_C2_RESTART    1
`define I2M_C2_STOP       2
`define I2M_C2_RECV       3
`define I2M_C2_ACKSEQ     4
`define I2M_C2_ACKDT      5
`define I2M_C2_ACKSTAT    6
`define I2M_ST_START      0
`define I2M_ST_STOP       1
`define I2M_ST_FULL       2
`define I2M_ST_BUSY       3
`define I2M_FL_EVENT      0
`define I2M_FL_WRITE_COLLISION_FLAG       1
`define I2M_FL_BCOL       2
`define I2M_PN_SDA_LOW    0
`define I2M_PN_SCL_LOW    1

// ******************************
// mode codes and reset values
// ******************************
`define I2M_MODE_MASTER   4'h8
`define I2M_MODE_FW       4'hb
`define I2M_RST_BAUD      8'h09
`define I2M_TX_BITS       4'h9
`define I2M_RX_BITS       4'h8
`define I2M_ACK_BITS      4'h1

`endif

// File: shared/i2m_pkg.sv
/*
 * types of the i2c master start/restart controller.
 * assumes i2m_map.svh for all numeric constants.
 */
package i2m_pkg;

   // master sequencer states, one-hot
   typedef enum logic [11:0] {
      I2M_IDLE    = 12'h001,
      I2M_ST_WAIT = 12'h002,
      I2M_ST_HOLD = 12'h004,
      I2M_RS_LOW  = 12'h008,
      I2M_RS_SDA  = 12'h010,
      I2M_RS_SCL  = 12'h020,
      I2M_RS_DRV  = 12'h040,
      I2M_BIT_LO  = 12'h080,
      I2M_BIT_HI  = 12'h100,
      I2M_SP_LO   = 12'h200,
      I2M_SP_HI   = 12'h400,
      I2M_SP_SDA  = 12'h800
   } i2m_state_t;

   typedef enum logic [1:0] {
      I2M_OP_TX  = 2'h0,
      I2M_OP_RX  = 2'h1,
      I2M_OP_ACK = 2'h2
   } i2m_op_t;

endpackage

// File: shared/i2m_baud_if.sv
/*
 * link between the sequencer and its baud rate counter.
 * assumes both ends run on pclk.
 */
`timescale 1ns/1ps
`default_nettype none

interface i2m_baud_if;
   logic       ce;
   logic       load;
   logic       run;
   logic [7:0] reload;
   logic       timeout;

   modport ctrl (output ce, output load, output run, output reload, input timeout);
   modport cnt  (input ce, input load, input run, input reload, output timeout);
endinterface

`default_nettype wire

// File: core/i2m_baud_counter.sv
/*
 * baud rate counter: counts down from the reload value, one baud period
 * per rollover.
 * assumes the sequencer steers load and run every cycle.
 */
`timescale 1ns/1ps
`default_nettype none

module i2m_baud_counter (
   // clock and reset
   input  wire logic presetn,
   input  wire logic pclk,
   // sequencer side
   i2m_baud_if.cnt   bd
);

   logic [7:0] cnt_q;
   logic       zero;

   assign zero       = (cnt_q == 8'h00);
   assign bd.timeout = bd.run & ~bd.load & zero;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 8'h00;
      end else if (bd.ce) begin
         if (bd.load || (bd.run && zero)) begin
            cnt_q <= bd.reload;
         end else if (bd.run) begin
            cnt_q <= cnt_q - 8'h01;
         end
      end
   end

endmodule

`default_nettype wire

// File: tb/i2m_master_properties.sv
/* port assertions of the i2c master controller.
   assumes pulled-up lines on sda_i/scl_i and a 32-bit apb master. */
`timescale 1ns/1ps
`default_nettype none
module i2m_master_properties (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // lines
   input wire logic        sda_i,
   input wire logic        scl_i,
   input wire logic        sda_o,
   input wire logic        scl_o,
   input wire logic        sda_oe,
   input wire logic        scl_oe
);
   // ********************************
   // shadows of baud and enable, high-time counts
   // ********************************
   logic [7:0] baud_q;
   logic       en_q;
   logic [8:0] hi_q;
   logic [8:0] both_q;
   wire        wr_w = psel && penable && pwrite;
   wire        mode_w = pwdata[5] && (pwdata[3:0] == 4'h8 || pwdata[3:0] == 4'hb);
   // counts saturate so a long idle never wraps to a small value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         baud_q <= 8'h09;
         en_q <= 1'b0;
         hi_q <= 9'h000;
         both_q <= 9'h000;
      end else begin
         if (wr_w && paddr == 8'h10) baud_q <= pwdata[7:0];
         if (wr_w && paddr == 8'h00) en_q <= mode_w;
         hi_q <= scl_i ? hi_q + {8'h00, hi_q != 9'h1ff} : 9'h000;
         both_q <= (scl_i && sda_i) ? both_q + {8'h00, both_q != 9'h1ff} : 9'h000;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_zero_wait: assert property (psel && penable |-> pready) else $error("access not ready");
   a_err_access: assert property (!penable |-> !pslverr) else $error("error outside access");
   a_unmapped_err: assert property (psel && penable && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h18))
      else $error("wrong error response");
   a_open_drain: assert property (!sda_o && !scl_o) else $error("line driven high");
   a_off_released: assert property (!en_q |-> ##2 (!sda_oe && !scl_oe)) else $error("line held while off");
   a_start_setup: assert property ($rose(sda_oe) && scl_i && !scl_oe |-> both_q >= {1'b0, baud_q} + 9'h001)
      else $error("start without full high count");
   a_start_hold: assert property ($rose(sda_oe) && scl_i && !scl_oe && baud_q >= 8'h02 |-> sda_oe [*3])
      else $error("start data low too short");
   a_scl_high: assert property ($rose(scl_oe) |-> hi_q >= {1'b0, baud_q} + 9'h001)
      else $error("clock high time short");
   c_start: cover property ($rose(sda_oe) && scl_i);
   c_clock: cover property ($rose(scl_oe));
   c_error: cover property (psel && penable && pslverr);
endmodule
bind i2m_master i2m_master_properties i2m_master_properties_i (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
   .pslverr, .sda_i, .scl_i, .sda_o, .scl_o, .sda_oe, .scl_oe
);
`default_nettype wire

// File: tb/i2m_bus_model.sv
/* i2c target with pull-ups: acks the ninth clock, may stretch or hold scl.
   assumes the master pulls lines only through its enables. */
`timescale 1ns/1ps
`default_nettype none
module i2m_bus_model (
   // clock
   input  wire logic pclk,
   // master pull-downs
   input  wire logic sda_oe,
   input  wire logic scl_oe,
   // scenario controls
   input  wire logic stretch,
   input  wire logic hold_scl,
   // lines and last bits seen
   output logic       sda,
   output logic       scl,
   output logic [8:0] seen
);
   // ********************************
   // wired lines and target behaviour
   // ********************************
   logic       ack_q = 1'b0;
   logic [2:0] st_q = 3'h0;
   logic [3:0] fall_q = 4'h0;
   logic       sda_q = 1'b1;
   logic       scl_q = 1'b1;
   // released lines float high through the pull-ups
   assign sda = !(sda_oe || ack_q);
   assign scl = !(scl_oe || hold_scl || st_q != 3'h0);
   always @(posedge pclk) begin
      sda_q <= sda;
      scl_q <= scl;
      if (st_q != 3'h0) st_q <= st_q - 3'h1;
      if (scl_q && scl && sda_q && !sda) fall_q <= 4'h0;
      else if (scl_q && !scl) begin
         fall_q <= fall_q + 4'h1;
         ack_q <= (fall_q == 4'h8);
         if (stretch) st_q <= 3'h6;
      end
      if (!scl_q && scl) seen <= {seen[7:0], sda};
   end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
/* self-checking bench of the i2c master: apb sequences against the target.
   assumes the register map header and zero-wait apb answers. */
`timescale 1ns/1ps
`default_nettype none
`include "i2m_map.svh"
module tb_top;
   // ********************************
   // signals, instances, tasks
   // ********************************
   localparam logic [7:0] ofs_c1 = `I2M_OFS_CTRL1;
   localparam logic [7:0] ofs_c2 = `I2M_OFS_CTRL2;
   localparam logic [7:0] ofs_st = `I2M_OFS_STATUS;
   localparam logic [7:0] ofs_fl = `I2M_OFS_FLAGS;
   localparam logic [7:0] ofs_bd = `I2M_OFS_BAUD;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        stretch = 1'b0;
   logic        hold_scl = 1'b0;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, sda_o, sda_oe, scl_o, scl_oe, sda, scl, err_seen;
   logic [8:0]  seen;
   int          errors = 0;
   int          checks = 0;
   int          cycles = 0;
   i2m_master i2m_master_i (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .sda_i(sda), .sda_o, .sda_oe, .scl_i(scl), .scl_o, .scl_oe);
   i2m_bus_model i2m_bus_model_i (.pclk, .sda_oe, .scl_oe, .stretch, .hold_scl, .sda, .scl, .seen);
   initial forever #50 pclk = ~pclk;
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err_seen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(n, e, rd & m);
   endtask
   task automatic pins(input logic [1:0] e);
      @(negedge pclk);
      chk("pull enables", {30'h0, e}, {30'h0, scl_oe, sda_oe});
   endtask
   task automatic wait_flag(input logic [31:0] m);
      int n = 0;
      do begin
         apb(1'b0, ofs_fl, 32'h0);
         n++;
      end while ((rd & m) === 32'h0 && n < 300);
      chk("flag wait", m, rd & m);
   endtask
   task automatic wrap_up;
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 40000) begin
         errors++;
         wrap_up;
      end
   end
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rchk("baud reset", ofs_bd, 32'hff, 32'h09);
      apb(1'b0, 8'h1c, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err_seen});
      apb(1'b1, ofs_c1, 32'h28);
      apb(1'b1, ofs_c2, 32'h1);
      apb(1'b1, ofs_c2, 32'h2);
      apb(1'b1, `I2M_OFS_BUF, 32'ha4);
      wait_flag(32'h1);
      rchk("start flags", ofs_fl, 32'h7, 32'h3);
      rchk("start request", ofs_c2, 32'h1f, 32'h0);
      rchk("start seen", ofs_st, 32'h1, 32'h1);
      pins(2'b01);
      apb(1'b1, ofs_fl, 32'h7);
      apb(1'b1, ofs_bd, 32'h3);
      stretch <= 1'b1;
      apb(1'b1, `I2M_OFS_BUF, 32'ha4);
      apb(1'b1, `I2M_OFS_BUF, 32'h55);
      wait_flag(32'h1);
      chk("frame", 32'h148, {23'h0, seen});
      rchk("transmit flags", ofs_fl, 32'h7, 32'h3);
      rchk("ack status", ofs_c2, 32'h5f, 32'h0);
      apb(1'b1, ofs_fl, 32'h7);
      apb(1'b1, ofs_c2, 32'h2);
      wait_flag(32'h1);
      rchk("restart request", ofs_c2, 32'h1f, 32'h0);
      rchk("restart seen", ofs_st, 32'h1, 32'h1);
      pins(2'b11);
      apb(1'b1, ofs_fl, 32'h7);
      apb(1'b1, ofs_c2, 32'h8);
      wait_flag(32'h1);
      rchk("received byte", `I2M_OFS_BUF, 32'hff, 32'hff);
      apb(1'b1, ofs_fl, 32'h7);
      apb(1'b1, ofs_c2, 32'h30);
      wait_flag(32'h1);
      rchk("ack sent", ofs_c2, 32'h1f, 32'h0);
      apb(1'b1, ofs_fl, 32'h7);
      apb(1'b1, ofs_c2, 32'h4);
      wait_flag(32'h1);
      rchk("stop seen", ofs_st, 32'h2, 32'h2);
      pins(2'b00);
      apb(1'b1, ofs_fl, 32'h7);
      apb(1'b1, ofs_c1, 32'h0);
      rchk("seen cleared", ofs_st, 32'h3, 32'h0);
      apb(1'b1, ofs_c1, 32'h2b);
      apb(1'b1, `I2M_OFS_PINS, 32'h1);
      repeat (4) @(posedge pclk);
      rchk("detected start", ofs_fl, 32'h1, 32'h1);
      hold_scl <= 1'b1;
      apb(1'b1, ofs_c1, 32'h28);
      apb(1'b1, ofs_c2, 32'h1);
      wait_flag(32'h4);
      rchk("aborted start", ofs_c2, 32'h1, 32'h0);
      pins(2'b00);
      hold_scl <= 1'b0;
      wrap_up;
   end
endmodule
`default_nettype wire
